/* core/preheader_crc_defs.vh */
/*
   Constants for the pre-header CRC-8 generator and checker: polynomial, seed,
   byte positions within the 12-byte pre-header.
   Assumes it is included by bare name from the design modules.
*/
// Contract
// - CRC-8 with polynomial x^8+x^7+x^6+x^4+x^2+1, eight-stage shift model.
// - CRC covers exactly pre-header bytes 1 to 11, stream id to second reserved.
// - Each covered byte enters most significant bit first, one bit after another.
// - CRC state preset to all ones before the first byte of every pre-header.
// - After byte 11 the result is the eight state bits, bit 7 down to 0.
// - Generator puts the computed CRC into pre-header byte 12.
// - Checker compares the computed CRC with received pre-header byte 12.
// - Bytes 01,00,55,AA then seven zeros give CRC 0x8A.
// - CRC generation and checking run whenever multi-stream mode is on.
`ifndef PREHEADER_CRC_DEFS_VH
`define PREHEADER_CRC_DEFS_VH

`define CRC_POLY 8'hD5
`define CRC_SEED 8'hFF
`define CRC_LAST_COVERED 4'hA
`define CRC_BYTE_POS 4'hB
`define PREHDR_LEN 4'hC

`endif

/* core/byte_skid_buffer.v */
/*
   Two-entry skid buffer with valid and ready on both sides.
   Assumes one clock and an asynchronous active-low reset; both sides are
   logic on the same clock.
*/
`timescale 1ns/10ps
module byte_skid_buffer #(
   parameter WIDTH = 9
)
(
   // Clock and reset.
   input wire clk,
   input wire reset_n,
   // Filling side.
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   // Draining side.
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] main_data_reg;
   reg main_valid_reg;
   reg [WIDTH-1:0] skid_data_reg;
   reg skid_valid_reg;
   reg ready_reg;
   wire push;
   wire pop;

   assign push = in_valid && ready_reg;
   assign pop = main_valid_reg && out_ready;
   assign in_ready = ready_reg;
   assign out_data = main_data_reg;
   assign out_valid = main_valid_reg;

   // The head entry drives the output; the skid entry catches a word taken
   // while the head is stalled, so ready may lag by one cycle without loss.
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         main_data_reg <= {WIDTH{1'b0}};
         main_valid_reg <= 1'b0;
         skid_data_reg <= {WIDTH{1'b0}};
         skid_valid_reg <= 1'b0;
         ready_reg <= 1'b0;
      end
      else
      begin
         if (!main_valid_reg || pop)
         begin
            if (skid_valid_reg)
            begin
               main_data_reg <= skid_data_reg;
               main_valid_reg <= 1'b1;
               skid_valid_reg <= push;
               skid_data_reg <= in_data;
            end
            else
            begin
               main_data_reg <= in_data;
               main_valid_reg <= push;
            end
         end
         else if (push)
         begin
            skid_data_reg <= in_data;
            skid_valid_reg <= 1'b1;
         end
         ready_reg <= !(skid_valid_reg || (push && main_valid_reg && !pop));
      end
   end
endmodule // byte_skid_buffer

/* core/preheader_crc8.v */
/*
   Byte-serial CRC-8 generator and checker for the 12-byte transport stream
   pre-header used in multi-stream mode. Bytes flow through a two-entry buffer;
   when generating, byte 12 is replaced by the CRC, when checking it is
   compared and a one-cycle match or mismatch pulse is given.
   Assumes the stream source marks the first pre-header byte with IN_SOP and
   sits on CLK_SYS; bytes after the 12th pass through untouched.
*/
`timescale 1ns/10ps
`include "preheader_crc_defs.vh"
module preheader_crc8 (
   // Clock and reset.
   input wire CLK_SYS,
   input wire RESET_N,
   // Mode control.
   input wire MULTI_STREAM_EN,
   input wire GEN_MODE,
   // Incoming byte stream.
   input wire [7:0] IN_DATA,
   input wire IN_SOP,
   input wire IN_VALID,
   output wire IN_READY,
   // Outgoing byte stream.
   output wire [7:0] OUT_DATA,
   output wire OUT_SOP,
   output wire OUT_VALID,
   input wire OUT_READY,
   // Check results.
   output wire [7:0] CRC_VALUE,
   output wire CRC_DONE,
   output wire CRC_MATCH,
   output wire CRC_MISMATCH
);
   reg [7:0] crc_reg;
   reg [7:0] crc_next;
   reg [3:0] pos_reg;
   reg [3:0] pos_next;
   reg active_reg;
   reg active_next;
   reg gen_reg;
   reg gen_next;
   reg [7:0] value_reg;
   reg [7:0] value_next;
   reg done_reg;
   reg done_next;
   reg match_reg;
   reg match_next;
   reg mismatch_reg;
   reg mismatch_next;
   reg [7:0] send_data;
   wire take;
   wire [3:0] pos_now;
   wire in_header;
   wire [7:0] crc_base;
   wire buf_ready;
   wire [7:0] crc_stage [0:8];
   genvar b;

   assign take = IN_VALID && buf_ready;
   assign pos_now = IN_SOP ? 4'h0 : pos_reg;
   assign in_header = MULTI_STREAM_EN && (IN_SOP || active_reg);
   assign crc_base = (pos_now == 4'h0) ? `CRC_SEED : crc_reg;
   assign crc_stage[0] = crc_base;

   // One covered byte through the eight-stage shift model, high bit first.
   generate
      for (b = 0; b < 8; b = b + 1)
      begin : g_bit
         wire fb;
         assign fb = crc_stage[b][7] ^ IN_DATA[7 - b];
         assign crc_stage[b + 1] = {crc_stage[b][6:0], 1'b0} ^ ({8{fb}} & `CRC_POLY);
      end
   endgenerate

   // Byte position tracking and CRC accumulation.
   always @*
   begin
      pos_next = pos_reg;
      active_next = active_reg;
      gen_next = gen_reg;
      crc_next = crc_reg;
      if (take && in_header)
      begin
         if (pos_now == 4'h0)
         begin
            gen_next = GEN_MODE;
         end
         if (pos_now <= `CRC_LAST_COVERED)
         begin
            crc_next = crc_stage[8];
         end
         pos_next = pos_now + 4'h1;
         active_next = (pos_now + 4'h1) < `PREHDR_LEN;
      end
      else if (take && IN_SOP)
      begin
         active_next = 1'b0;
      end
   end

   // Byte 12 handling: insertion when generating, comparison when checking.
   always @*
   begin
      send_data = IN_DATA;
      value_next = value_reg;
      done_next = 1'b0;
      match_next = 1'b0;
      mismatch_next = 1'b0;
      if (take && in_header && (pos_now == `CRC_BYTE_POS))
      begin
         value_next = crc_reg;
         done_next = 1'b1;
         if ((pos_now == 4'h0) ? GEN_MODE : gen_reg)
         begin
            send_data = crc_reg;
         end
         else
         begin
            match_next = (IN_DATA == crc_reg);
            mismatch_next = (IN_DATA != crc_reg);
         end
      end
   end

   always @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         crc_reg <= `CRC_SEED;
         pos_reg <= 4'h0;
         active_reg <= 1'b0;
         gen_reg <= 1'b0;
         value_reg <= 8'h00;
         done_reg <= 1'b0;
         match_reg <= 1'b0;
         mismatch_reg <= 1'b0;
      end
      else
      begin
         crc_reg <= crc_next;
         pos_reg <= pos_next;
         active_reg <= active_next;
         gen_reg <= gen_next;
         value_reg <= value_next;
         done_reg <= done_next;
         match_reg <= match_next;
         mismatch_reg <= mismatch_next;
      end
   end

   // A stall by the receiver holds IN_READY low; no taken byte is lost.
   byte_skid_buffer #(
      .WIDTH(9)
   )
   out_buffer (
      .clk(CLK_SYS),
      .reset_n(RESET_N),
      .in_data({IN_SOP, send_data}),
      .in_valid(IN_VALID),
      .in_ready(buf_ready),
      .out_data({OUT_SOP, OUT_DATA}),
      .out_valid(OUT_VALID),
      .out_ready(OUT_READY)
   );

   assign IN_READY = buf_ready;
   assign CRC_VALUE = value_reg;
   assign CRC_DONE = done_reg;
   assign CRC_MATCH = match_reg;
   assign CRC_MISMATCH = mismatch_reg;
endmodule // preheader_crc8

/* tb/preheader_crc8_assertions.sv */
/* Port assertions for preheader_crc8.
   Assumes binding to every instance of it. */
`timescale 1ns/10ps
module preheader_crc8_assertions (
   // Observed ports.
   input wire CLK_SYS,
   input wire RESET_N,
   input wire MULTI_STREAM_EN,
   input wire IN_VALID,
   input wire IN_READY,
   input wire [7:0] OUT_DATA,
   input wire OUT_SOP,
   input wire OUT_VALID,
   input wire OUT_READY,
   input wire [7:0] CRC_VALUE,
   input wire CRC_DONE,
   input wire CRC_MATCH,
   input wire CRC_MISMATCH
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   sequence stalled_in;
      (IN_VALID && !OUT_READY) [*6];
   endsequence
   done_cause_a: assert property (CRC_DONE |-> $past(IN_VALID && IN_READY))
      else $error("done without taken byte");
   pulse_once_a: assert property (CRC_DONE |=> !CRC_DONE)
      else $error("done too long");
   verdict_done_a: assert property ((CRC_MATCH || CRC_MISMATCH) |-> CRC_DONE)
      else $error("verdict without done");
   verdict_excl_a: assert property (CRC_DONE |-> !(CRC_MATCH && CRC_MISMATCH))
      else $error("both verdicts");
   value_hold_a: assert property ($changed(CRC_VALUE) |-> CRC_DONE)
      else $error("value moved");
   bypass_quiet_a: assert property (!MULTI_STREAM_EN |=> !CRC_DONE)
      else $error("done in bypass");
   stall_hold_a: assert property (OUT_VALID && !OUT_READY |=>
      OUT_VALID && $stable(OUT_DATA) && $stable(OUT_SOP)) else $error("output moved");
   full_stop_a: assert property (stalled_in |=> !IN_READY)
      else $error("buffer overrun");
endmodule // preheader_crc8_assertions

bind preheader_crc8 preheader_crc8_assertions u_chk (.*);

/* tb/stream_sink.sv */
/* Receiving partner: takes bytes, can stall, keeps the last frame.
   Assumes the clock and reset of the block. */
`timescale 1ns/10ps
module stream_sink (
   // Clock and reset.
   input wire clk,
   input wire reset_n,
   // Stream in.
   input wire [7:0] data,
   input wire sop,
   input wire valid,
   output reg ready,
   // Control.
   input wire stall
);
   reg [7:0] mem [0:15];
   reg [3:0] n;
   reg [2:0] cyc;
   // A stalling sink is ready one cycle in eight, so the buffer fills.
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ready <= 1'b0;
         n <= 4'h0;
         cyc <= 3'h0;
      end
      else
      begin
         cyc <= cyc + 3'h1;
         ready <= !stall || (&cyc);
         if (valid && ready)
         begin
            mem[sop ? 4'h0 : n] <= data;
            n <= sop ? 4'h1 : n + 4'h1;
         end
      end
   end
endmodule // stream_sink

/* tb/test_preheader_crc8.sv */
/* Bench for preheader_crc8: generate, check and bypass frames.
   Assumes stream_sink and the bound checker. */
`timescale 1ns/10ps
module test_preheader_crc8;
   reg clk = 1'b0, rst_n = 1'b0, en = 1'b0, gen = 1'b0, sop = 1'b0, vld = 1'b0, stall = 1'b0;
   reg [7:0] din = 8'h00, dn = 8'h00, mt = 8'h00, ms = 8'h00;
   wire rdy, osop, ovld, ordy, done, mat, mis;
   wire [7:0] dout, crc;
   integer fail_count = 0, compares = 0;
   preheader_crc8 u_dut (.CLK_SYS(clk), .RESET_N(rst_n), .MULTI_STREAM_EN(en), .GEN_MODE(gen),
      .IN_DATA(din), .IN_SOP(sop), .IN_VALID(vld), .IN_READY(rdy), .OUT_DATA(dout),
      .OUT_SOP(osop), .OUT_VALID(ovld), .OUT_READY(ordy), .CRC_VALUE(crc),
      .CRC_DONE(done), .CRC_MATCH(mat), .CRC_MISMATCH(mis));
   stream_sink u_sink (.clk(clk), .reset_n(rst_n), .data(dout), .sop(osop), .valid(ovld),
      .ready(ordy), .stall(stall));
   initial forever #4 clk = ~clk;
   always @(posedge clk)
   begin
      dn = dn + done;
      mt = mt + mat;
      ms = ms + mis;
   end
   task chk(input [7:0] seen, input [7:0] exp);
   begin
      compares = compares + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   // Sends the test vector, the given twelfth byte and one trailing byte.
   task run(input e, input g, input [7:0] last, input s);
      integer i;
   begin
      en <= e;
      gen <= g;
      stall <= s;
      dn = 8'h00;
      mt = 8'h00;
      ms = 8'h00;
      for (i = 0; i < 13; i = i + 1)
      begin
         sop <= (i == 0);
         din <= i == 0 ? 8'h01 : i == 2 ? 8'h55 : i == 3 ? 8'hAA : i == 11 ? last :
            i == 12 ? 8'h5A : 8'h00;
         vld <= 1'b1;
         @(posedge clk);
         while (rdy !== 1'b1) @(posedge clk);
      end
      vld <= 1'b0;
      for (i = 0; i < 200 && u_sink.n != 4'hD; i = i + 1) @(posedge clk);
   end
   endtask
   task t_gen;
   begin
      run(1'b1, 1'b1, 8'h00, 1'b0);
      chk(u_sink.mem[11], 8'h8A);
      chk(crc, 8'h8A);
      chk(u_sink.mem[12], 8'h5A);
      chk(u_sink.mem[0], 8'h01);
      chk(dn, 8'h01);
   end
   endtask
   task t_chk_ok;
   begin
      run(1'b1, 1'b0, 8'h8A, 1'b0);
      chk(mt, 8'h01);
      chk(u_sink.mem[11], 8'h8A);
   end
   endtask
   task t_chk_bad;
   begin
      run(1'b1, 1'b0, 8'h8B, 1'b1);
      chk(ms, 8'h01);
      chk(mt, 8'h00);
      chk(crc, 8'h8A);
   end
   endtask
   task t_bypass;
   begin
      run(1'b0, 1'b1, 8'h3C, 1'b0);
      chk(dn, 8'h00);
      chk(u_sink.mem[11], 8'h3C);
   end
   endtask
   // An abandoned pre-header must not leak into the next one.
   task t_restart;
      integer i;
   begin
      en <= 1'b1;
      gen <= 1'b1;
      stall <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
      begin
         sop <= (i == 0);
         din <= 8'hC3;
         vld <= 1'b1;
         @(posedge clk);
         while (rdy !== 1'b1) @(posedge clk);
      end
      run(1'b1, 1'b1, 8'h00, 1'b0);
      chk(crc, 8'h8A);
      chk(dn, 8'h01);
   end
   endtask
   // Reset between frames clears the results, then a fresh frame still works.
   task t_reset;
   begin
      rst_n <= 1'b0;
      @(negedge clk);
      chk(crc, 8'h00);
      chk({5'h00, rdy, ovld, done}, 8'h00);
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      run(1'b1, 1'b1, 8'h00, 1'b0);
      chk(crc, 8'h8A);
      chk(u_sink.mem[11], 8'h8A);
   end
   endtask
   task wrap_up;
   begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_gen;
      t_chk_ok;
      t_chk_bad;
      t_bypass;
      t_restart;
      t_reset;
      wrap_up;
   end
   initial
   begin
      #20000;
      fail_count = fail_count + 1;
      wrap_up;
   end
endmodule // test_preheader_crc8
